/* inc/seq_defs.svh */
// Purpose: Timing, speed and pin-index constants of the start/transfer sequencer
// Assumes: Controller clock of 200 MHz, slow timebase of ten ticks a second
// Notes:   Times are in seconds except STALL_MS in milliseconds; tick and cycle counts derive from them
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH

`define CLK_HZ          200000000
`define TICKS_PER_S     10
`define TMR_W           12

`define DROP_PCT        65
`define RETURN_PCT      75
`define LINE_INT_S      10
`define REFAIL_S        3
`define RETURN_S        15
`define WARMUP_S        5
`define COOL_S          60
`define CRANK_LONG_S    16
`define CRANK_SHORT_S   7
`define REST_S          7
`define LONG_CRANKS     2
`define CRANK_CYCLES    5
`define SENSE_S         3
`define ACCEL_S         15
`define LOCKOUT_S       5
`define HOLDOFF_S       10

`define DROP_RPM        1000
`define RUN_RPM         2200
`define DROP_COUNT      4
`define PULSES_PER_REV  1
`define STALL_MS        500

`define NUM_PINS        8
`define PIN_AUTO        0
`define PIN_MANUAL      1
`define PIN_EXERCISE    2
`define PIN_BELOW_DROP  3
`define PIN_ABOVE_RET   4
`define PIN_SPEED       5
`define PIN_ALARM       6
`define PIN_FAULT_CLR   7

`endif

/* inc/seq_pkg.sv */
// Purpose: Types shared by the start/transfer sequencer
// Assumes: Nothing beyond the constants header
// Notes:   Engine states follow a Gray path off-crank-accel-run-cool
package seq_pkg;
  typedef enum logic [2:0] {
    ST_OFF   = 3'h0,
    ST_CRANK = 3'h1,
    ST_ACCEL = 3'h3,
    ST_RUN   = 3'h2,
    ST_COOL  = 3'h6,
    ST_REST  = 3'h7,
    ST_FAULT = 3'h5
  } eng_state_e;
endpackage

/* logic/tick_gen.sv */
// Purpose: Slow timebase, one-cycle tick every DIV clocks
// Assumes: DIV of at least two
// Notes:   All sequencer timers advance on this tick
module tick_gen #(
  parameter int DIV = 20000000
) (
  input  wire logic CLK,
  input  wire logic RST,
  output logic      tick
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_reg;

  always_ff @(posedge CLK) begin
    if (RST) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else begin
      tick <= (cnt_reg == LAST);
      if (cnt_reg == LAST) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
endmodule

/* logic/speed_meter.sv */
// Purpose: Engine speed judgement from the synchronised magneto pulse
// Assumes: pulse is already two-flop synchronised to CLK
// Notes:   Period measured edge to edge in clock cycles
module speed_meter #(
  parameter int DROP_PERIOD = 12000000,
  parameter int RUN_PERIOD  = 5454540,
  parameter int STALL       = 100000000,
  parameter int DROP_COUNT  = 4
) (
  input  wire logic CLK,
  input  wire logic RST,
  input  wire logic pulse,
  output logic      edge_seen,
  output logic      drop_ok,
  output logic      run_ok,
  output logic      stopped
);
  localparam int W  = $clog2(STALL + 1);
  localparam int CW = $clog2(DROP_COUNT + 1);
  localparam logic [W-1:0]  P_DROP = W'(DROP_PERIOD);
  localparam logic [W-1:0]  P_RUN  = W'(RUN_PERIOD);
  localparam logic [W-1:0]  P_STOP = W'(STALL);
  localparam logic [CW-1:0] N_DROP = CW'(DROP_COUNT);

  logic          prev_reg;
  logic [W-1:0]  per_reg;
  logic [CW-1:0] fast_reg;
  logic          rise;

  assign rise      = pulse & ~prev_reg;
  assign edge_seen = rise;
  assign drop_ok   = (fast_reg == N_DROP);
  assign stopped   = (per_reg == P_STOP);

  always_ff @(posedge CLK) begin
    if (RST) begin
      prev_reg <= 1'b0;
      per_reg  <= P_STOP;
      fast_reg <= '0;
      run_ok   <= 1'b0;
    end else begin
      prev_reg <= pulse;
      if (rise) begin
        per_reg <= '0;
        run_ok  <= (per_reg <= P_RUN);
        // Consecutive periods at or above dropout speed
        if (per_reg > P_DROP) begin
          fast_reg <= '0;
        end else if (fast_reg != N_DROP) begin
          fast_reg <= fast_reg + 1'b1;
        end
      end else if (per_reg != P_STOP) begin
        per_reg <= per_reg + 1'b1;
      end else begin
        fast_reg <= '0;
        run_ok   <= 1'b0;
      end
    end
  end
endmodule

/* logic/standby_start_transfer_seq.sv */
// Purpose: Start, crank and transfer sequencer of a standby generator
// Assumes: Selector, utility comparators, speed and alarm arrive as pins
// Notes:   Ten-tick-per-second timebase; all outputs registered
//
// How it works
// - Auto, utility below 65%: start ten second interruption delay.
// - Utility still absent when delay expires: crank and start engine.
// - After start run five second warm-up, then contactor to generator.
// - Utility back before warm-up end: finish, cool down, stay on utility.
// - Crank 16/7, 16/7, then three 7 s cranks with 7 s rests.
// - Dropout is four speed cycles at 1000 rpm or faster.
// - Flag failed start; missing 2200 rpm in 15 s rests then resumes.
// - Rest: starter and fuel off, magneto grounded.
// - Starter waits five seconds after the engine last stopped.
// - Starter and magneto together; fuel off at starter energise.
// - No speed signal within three seconds: stop, latch sensor loss.
// - First speed signal: fuel on, throttle open, keep cranking.
// - Starter off once dropout speed is reached.
// - Stall between dropout and 2200 rpm: rest 7 s, re-crank if left.
// - Wait a hold-off before enabling oil protections.
// - Manual crank aborts at once when selector goes to off.
// - Auto crank completes despite utility return; then run a minute.
// - Manual: transfer after 10 s failure, return after 15 s good.
// - Auto: retransfer after 15 s good, then one minute cool-down.
// - Any shutdown returns contactor to utility if utility present.
// - Exercise ignored when running; transfers only after 10 s failure.
// - Utility fails three seconds during cool-down: back to generator.
`include "seq_defs.svh"

module standby_start_transfer_seq #(
  parameter int TICK_CYCLES  = `CLK_HZ / `TICKS_PER_S,
  parameter int DROP_PERIOD  = `CLK_HZ / (`DROP_RPM * `PULSES_PER_REV) * 60,
  parameter int RUN_PERIOD   = `CLK_HZ / (`RUN_RPM * `PULSES_PER_REV) * 60,
  parameter int STALL_CYCLES = `CLK_HZ / 1000 * `STALL_MS,
  parameter int HOLDOFF_S    = `HOLDOFF_S
) (
  input  wire logic CLK,
  input  wire logic RST,
  input  wire logic SEL_AUTO,
  input  wire logic SEL_MANUAL,
  input  wire logic EXERCISE_REQ,
  input  wire logic UTIL_BELOW_DROP,
  input  wire logic UTIL_ABOVE_RETURN,
  input  wire logic SPEED_PULSE,
  input  wire logic SHUTDOWN_ALARM,
  input  wire logic FAULT_CLEAR,
  output logic      STARTER_ON,
  output logic      MAGNETO_GROUND,
  output logic      FUEL_ON,
  output logic      THROTTLE_OPEN,
  output logic      CONTACTOR_STANDBY,
  output logic      ENGINE_RUNNING,
  output logic      PROT_ENABLE,
  output logic      SENSOR_LOSS,
  output logic      START_FAILED
);
  import seq_pkg::*;

  localparam int TW = `TMR_W;
  localparam logic [TW-1:0] T_LINE   = TW'(`LINE_INT_S * `TICKS_PER_S);
  localparam logic [TW-1:0] T_REFAIL = TW'(`REFAIL_S * `TICKS_PER_S);
  localparam logic [TW-1:0] T_RETURN = TW'(`RETURN_S * `TICKS_PER_S);
  localparam logic [TW-1:0] T_WARM   = TW'(`WARMUP_S * `TICKS_PER_S);
  localparam logic [TW-1:0] T_COOL   = TW'(`COOL_S * `TICKS_PER_S);
  localparam logic [TW-1:0] T_CLONG  = TW'(`CRANK_LONG_S * `TICKS_PER_S);
  localparam logic [TW-1:0] T_CSHORT = TW'(`CRANK_SHORT_S * `TICKS_PER_S);
  localparam logic [TW-1:0] T_REST   = TW'(`REST_S * `TICKS_PER_S);
  localparam logic [TW-1:0] T_SENSE  = TW'(`SENSE_S * `TICKS_PER_S);
  localparam logic [TW-1:0] T_ACCEL  = TW'(`ACCEL_S * `TICKS_PER_S);
  localparam logic [TW-1:0] T_LOCK   = TW'(`LOCKOUT_S * `TICKS_PER_S);
  localparam logic [TW-1:0] T_HOLD   = TW'(HOLDOFF_S * `TICKS_PER_S);
  localparam logic [TW-1:0] T_RMAX   = (T_HOLD > T_WARM) ? T_HOLD : T_WARM;
  localparam logic [TW-1:0] T_MAX    = '1;
  localparam logic [2:0] LAST_CYCLE  = 3'(`CRANK_CYCLES - 1);
  localparam logic [2:0] LONG_CYCLES = 3'(`LONG_CRANKS);

  // Pin synchronisers
  logic [`NUM_PINS-1:0] pin_raw;
  logic [`NUM_PINS-1:0] meta_reg;
  logic [`NUM_PINS-1:0] sync_reg;

  assign pin_raw[`PIN_AUTO]       = SEL_AUTO;
  assign pin_raw[`PIN_MANUAL]     = SEL_MANUAL;
  assign pin_raw[`PIN_EXERCISE]   = EXERCISE_REQ;
  assign pin_raw[`PIN_BELOW_DROP] = UTIL_BELOW_DROP;
  assign pin_raw[`PIN_ABOVE_RET]  = UTIL_ABOVE_RETURN;
  assign pin_raw[`PIN_SPEED]      = SPEED_PULSE;
  assign pin_raw[`PIN_ALARM]      = SHUTDOWN_ALARM;
  assign pin_raw[`PIN_FAULT_CLR]  = FAULT_CLEAR;

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_PINS; gi++) begin : g_sync
      always_ff @(posedge CLK) begin
        if (RST) begin
          meta_reg[gi] <= 1'b0;
          sync_reg[gi] <= 1'b0;
        end else begin
          meta_reg[gi] <= pin_raw[gi];
          sync_reg[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

  logic auto_m;
  logic manual_m;
  logic off_m;
  logic stop_now;

  assign auto_m   = sync_reg[`PIN_AUTO] & ~sync_reg[`PIN_MANUAL];
  assign manual_m = sync_reg[`PIN_MANUAL] & ~sync_reg[`PIN_AUTO];
  assign off_m    = ~auto_m & ~manual_m;
  assign stop_now = off_m | sync_reg[`PIN_ALARM];

  // Timebase and speed judgement
  logic tick;
  logic spd_edge;
  logic spd_drop;
  logic spd_run;
  logic spd_stop;

  tick_gen #(.DIV(TICK_CYCLES)) u_tick (
    .CLK  (CLK),
    .RST  (RST),
    .tick (tick)
  );

  speed_meter #(
    .DROP_PERIOD (DROP_PERIOD),
    .RUN_PERIOD  (RUN_PERIOD),
    .STALL       (STALL_CYCLES),
    .DROP_COUNT  (`DROP_COUNT)
  ) u_speed (
    .CLK       (CLK),
    .RST       (RST),
    .pulse     (sync_reg[`PIN_SPEED]),
    .edge_seen (spd_edge),
    .drop_ok   (spd_drop),
    .run_ok    (spd_run),
    .stopped   (spd_stop)
  );

  // Utility judgement with hysteresis
  logic util_good_reg;

  always_ff @(posedge CLK) begin
    if (RST) begin
      util_good_reg <= 1'b1;
    end else if (sync_reg[`PIN_ABOVE_RET]) begin
      util_good_reg <= 1'b1;
    end else if (sync_reg[`PIN_BELOW_DROP]) begin
      util_good_reg <= 1'b0;
    end
  end

  // Consecutive failed and good utility time
  logic [TW-1:0] fail_cnt_reg;
  logic [TW-1:0] good_cnt_reg;
  logic          fail_long;
  logic          fail_short;
  logic          good_long;

  always_ff @(posedge CLK) begin
    if (RST) begin
      fail_cnt_reg <= '0;
      good_cnt_reg <= '0;
    end else begin
      if (util_good_reg) begin
        fail_cnt_reg <= '0;
      end else if (tick && fail_cnt_reg != T_MAX) begin
        fail_cnt_reg <= fail_cnt_reg + 1'b1;
      end
      if (!util_good_reg) begin
        good_cnt_reg <= '0;
      end else if (tick && good_cnt_reg != T_MAX) begin
        good_cnt_reg <= good_cnt_reg + 1'b1;
      end
    end
  end

  assign fail_long  = (fail_cnt_reg >= T_LINE);
  assign fail_short = (fail_cnt_reg >= T_REFAIL);
  assign good_long  = (good_cnt_reg >= T_RETURN);

  // Engine sequencer
  eng_state_e    state_reg;
  logic [TW-1:0] tmr_reg;
  logic [2:0]    cycle_reg;
  logic          seen_reg;
  logic          outage_reg;
  logic          exer_reg;
  logic          start_req;
  logic [TW-1:0] crank_len;
  logic          running;

  assign start_req = manual_m | (auto_m & (outage_reg | exer_reg));
  assign crank_len = (cycle_reg < LONG_CYCLES) ? T_CLONG : T_CSHORT;
  assign running   = (state_reg == ST_RUN) || (state_reg == ST_COOL);

  // Time since the engine last stopped
  logic [TW-1:0] stop_cnt_reg;

  always_ff @(posedge CLK) begin
    if (RST) begin
      stop_cnt_reg <= '0;
    end else if (state_reg != ST_OFF && state_reg != ST_FAULT) begin
      stop_cnt_reg <= '0;
    end else if (tick && stop_cnt_reg != T_LOCK) begin
      stop_cnt_reg <= stop_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg    <= ST_OFF;
      tmr_reg      <= '0;
      cycle_reg    <= '0;
      seen_reg     <= 1'b0;
      SENSOR_LOSS  <= 1'b0;
      START_FAILED <= 1'b0;
    end else begin
      if (tick && tmr_reg != T_MAX) begin
        tmr_reg <= tmr_reg + 1'b1;
      end
      if (stop_now && state_reg != ST_OFF) begin
        state_reg    <= ST_OFF;
        tmr_reg      <= '0;
        SENSOR_LOSS  <= 1'b0;
        START_FAILED <= 1'b0;
      end else begin
        case (state_reg)
          ST_OFF: begin
            if (start_req && !stop_now && stop_cnt_reg == T_LOCK) begin
              state_reg <= ST_CRANK;
              tmr_reg   <= '0;
              cycle_reg <= '0;
              seen_reg  <= 1'b0;
            end
          end
          ST_CRANK: begin
            if (spd_edge) begin
              seen_reg <= 1'b1;
            end
            if (spd_drop) begin
              state_reg <= ST_ACCEL;
              tmr_reg   <= '0;
            end else if (!seen_reg && tmr_reg >= T_SENSE) begin
              state_reg   <= ST_FAULT;
              SENSOR_LOSS <= 1'b1;
            end else if (tmr_reg >= crank_len) begin
              state_reg <= ST_REST;
              tmr_reg   <= '0;
            end
          end
          ST_ACCEL: begin
            if (spd_run) begin
              state_reg <= ST_RUN;
              tmr_reg   <= '0;
            end else if (spd_stop || tmr_reg >= T_ACCEL) begin
              state_reg <= ST_REST;
              tmr_reg   <= '0;
            end
          end
          ST_REST: begin
            if (tmr_reg >= T_REST) begin
              tmr_reg <= '0;
              if (cycle_reg == LAST_CYCLE) begin
                state_reg    <= ST_FAULT;
                START_FAILED <= 1'b1;
              end else begin
                state_reg <= ST_CRANK;
                cycle_reg <= cycle_reg + 1'b1;
                seen_reg  <= 1'b0;
              end
            end
          end
          ST_RUN: begin
            if (!start_req) begin
              state_reg <= ST_COOL;
              tmr_reg   <= '0;
            end
          end
          ST_COOL: begin
            if (start_req) begin
              state_reg <= ST_RUN;
            end else if (tmr_reg >= T_COOL) begin
              state_reg <= ST_OFF;
              tmr_reg   <= '0;
            end
          end
          ST_FAULT: begin
            if (sync_reg[`PIN_FAULT_CLR]) begin
              state_reg    <= ST_OFF;
              tmr_reg      <= '0;
              SENSOR_LOSS  <= 1'b0;
              START_FAILED <= 1'b0;
            end
          end
          default: begin
            state_reg <= ST_OFF;
          end
        endcase
      end
    end
  end

  // Run time for warm-up and protection hold-off
  logic [TW-1:0] run_cnt_reg;
  logic          warm_done;
  logic          warm_q_reg;
  logic          warm_expire;

  always_ff @(posedge CLK) begin
    if (RST) begin
      run_cnt_reg <= '0;
      warm_q_reg  <= 1'b0;
    end else begin
      warm_q_reg <= warm_done;
      if (!running) begin
        run_cnt_reg <= '0;
      end else if (tick && run_cnt_reg != T_RMAX) begin
        run_cnt_reg <= run_cnt_reg + 1'b1;
      end
    end
  end

  assign warm_done   = (run_cnt_reg >= T_WARM);
  assign warm_expire = warm_done & ~warm_q_reg;

  // Outage demand: starts the engine in auto, transfers in auto and manual
  always_ff @(posedge CLK) begin
    if (RST) begin
      outage_reg <= 1'b0;
    end else if (off_m) begin
      outage_reg <= 1'b0;
    end else if (fail_long) begin
      outage_reg <= 1'b1;
    end else if (state_reg == ST_COOL && auto_m && fail_short) begin
      outage_reg <= 1'b1;
    end else if (good_long) begin
      outage_reg <= 1'b0;
    end else if (warm_expire && util_good_reg) begin
      outage_reg <= 1'b0;
    end
  end

  // Exercise accepted only from a stopped engine in auto
  always_ff @(posedge CLK) begin
    if (RST) begin
      exer_reg <= 1'b0;
    end else if (!auto_m || !sync_reg[`PIN_EXERCISE]) begin
      exer_reg <= 1'b0;
    end else if (state_reg == ST_OFF && !outage_reg) begin
      exer_reg <= 1'b1;
    end
  end

  // Transfer contactor
  always_ff @(posedge CLK) begin
    if (RST) begin
      CONTACTOR_STANDBY <= 1'b0;
    end else if (state_reg == ST_RUN && warm_done && outage_reg
                 && !util_good_reg) begin
      CONTACTOR_STANDBY <= 1'b1;
    end else if (util_good_reg && (!outage_reg || !running)) begin
      CONTACTOR_STANDBY <= 1'b0;
    end
  end

  // Engine outputs
  always_ff @(posedge CLK) begin
    if (RST) begin
      STARTER_ON     <= 1'b0;
      MAGNETO_GROUND <= 1'b1;
      FUEL_ON        <= 1'b0;
      THROTTLE_OPEN  <= 1'b0;
      ENGINE_RUNNING <= 1'b0;
      PROT_ENABLE    <= 1'b0;
    end else begin
      STARTER_ON     <= (state_reg == ST_CRANK);
      MAGNETO_GROUND <= !(state_reg == ST_CRANK || state_reg == ST_ACCEL
                          || running);
      FUEL_ON        <= (state_reg == ST_CRANK && seen_reg)
                        || state_reg == ST_ACCEL || running;
      THROTTLE_OPEN  <= (state_reg == ST_CRANK && seen_reg)
                        || state_reg == ST_ACCEL || running;
      ENGINE_RUNNING <= running;
      PROT_ENABLE    <= running && run_cnt_reg >= T_HOLD;
    end
  end
endmodule

/* sim/seq_monitor.sv */
// Purpose: Port checker of the start/transfer sequencer
// Assumes: Bound to the sequencer top, timebase of TICK_CYCLES clocks
// Notes:   One tick of slack, two for the early loss bound, covers tick phase and input sync
module seq_monitor #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SEL_AUTO,
  input wire logic SEL_MANUAL,
  input wire logic EXERCISE_REQ,
  input wire logic UTIL_BELOW_DROP,
  input wire logic UTIL_ABOVE_RETURN,
  input wire logic SPEED_PULSE,
  input wire logic SHUTDOWN_ALARM,
  input wire logic FAULT_CLEAR,
  input wire logic STARTER_ON,
  input wire logic MAGNETO_GROUND,
  input wire logic FUEL_ON,
  input wire logic THROTTLE_OPEN,
  input wire logic CONTACTOR_STANDBY,
  input wire logic ENGINE_RUNNING,
  input wire logic PROT_ENABLE,
  input wire logic SENSOR_LOSS,
  input wire logic START_FAILED
);
  timeunit 1ns;
  timeprecision 100ps;
  // Tick phase can make the loss arrive two ticks short of three seconds
  localparam int LOSS_MIN = 28 * TICK_CYCLES;
  localparam int LOSS_MAX = 31 * TICK_CYCLES + 10;
  localparam int HOLD_MIN = 49 * TICK_CYCLES;
  int idle;
  int quiet;
  int run_cyc;

  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  // Cycles since the engine was last stopped
  always_ff @(posedge CLK) begin
    if (RST || !MAGNETO_GROUND) idle <= 0;
    else idle <= idle + 1;
  end
  // Cycles of cranking without a speed pulse
  always_ff @(posedge CLK) begin
    if (RST || !STARTER_ON || SPEED_PULSE) quiet <= 0;
    else quiet <= quiet + 1;
  end
  always_ff @(posedge CLK) begin
    if (RST || !ENGINE_RUNNING) run_cyc <= 0;
    else run_cyc <= run_cyc + 1;
  end

  AST_STARTER_WITH_MAG: assert property ($rose(STARTER_ON) |->
    !MAGNETO_GROUND && !FUEL_ON) else $error("starter alone");
  AST_REST_SAFE: assert property (MAGNETO_GROUND |->
    !STARTER_ON && !FUEL_ON) else $error("output live at rest");
  AST_FUEL_ON_EDGE: assert property (
    STARTER_ON && !FUEL_ON && $rose(SPEED_PULSE)
    |-> ##[1:8] FUEL_ON && THROTTLE_OPEN) else $error("no fuel");
  AST_OFF_ABORT: assert property (
    $fell(SEL_MANUAL) && !SEL_AUTO |-> ##[1:8] !STARTER_ON && MAGNETO_GROUND)
    else $error("manual crank kept");
  AST_SENSE_LIMIT: assert property (STARTER_ON |-> quiet <= LOSS_MAX)
    else $error("crank without rotation");
  AST_SENSE_LATE: assert property ($rose(SENSOR_LOSS) |->
    $past(quiet, 2) >= LOSS_MIN) else $error("early sensor loss");
  AST_LOCKOUT: assert property ($rose(STARTER_ON) |-> idle >= HOLD_MIN)
    else $error("starter inside lockout");
  AST_WARMUP: assert property ($rose(CONTACTOR_STANDBY) |->
    run_cyc >= HOLD_MIN) else $error("transfer before warm-up");
  AST_ALARM_STOP: assert property (
    (SHUTDOWN_ALARM && UTIL_ABOVE_RETURN) [*3] |->
    ##[1:8] MAGNETO_GROUND && !CONTACTOR_STANDBY) else $error("alarm kept");

  cover property ($rose(CONTACTOR_STANDBY));
  cover property ($rose(SENSOR_LOSS));
  cover property ($rose(START_FAILED));
endmodule

bind standby_start_transfer_seq seq_monitor #(.TICK_CYCLES(TICK_CYCLES))
  u_seq_monitor (.CLK(CLK), .RST(RST), .SEL_AUTO(SEL_AUTO),
  .SEL_MANUAL(SEL_MANUAL), .EXERCISE_REQ(EXERCISE_REQ),
  .UTIL_BELOW_DROP(UTIL_BELOW_DROP), .UTIL_ABOVE_RETURN(UTIL_ABOVE_RETURN),
  .SPEED_PULSE(SPEED_PULSE), .SHUTDOWN_ALARM(SHUTDOWN_ALARM),
  .FAULT_CLEAR(FAULT_CLEAR), .STARTER_ON(STARTER_ON),
  .MAGNETO_GROUND(MAGNETO_GROUND), .FUEL_ON(FUEL_ON),
  .THROTTLE_OPEN(THROTTLE_OPEN), .CONTACTOR_STANDBY(CONTACTOR_STANDBY),
  .ENGINE_RUNNING(ENGINE_RUNNING), .PROT_ENABLE(PROT_ENABLE),
  .SENSOR_LOSS(SENSOR_LOSS), .START_FAILED(START_FAILED));

/* sim/engine_model.sv */
// Purpose: Engine and magneto pickup as seen from the sequencer pins
// Assumes: behave 0 starts, 1 never turns, 2 only cranks slowly
// Notes:   Pickup line idles low while the engine stands still
module engine_model (
  input  wire logic       clk,
  input  wire logic       starter,
  input  wire logic       mag_ground,
  input  wire logic       fuel,
  input  wire logic [1:0] behave,
  output logic            speed_pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  int period;
  int cnt = 0;

  initial speed_pulse = 1'b0;
  // Pulse period in clocks; zero means no rotation
  always_comb begin
    period = 0;
    if (!mag_ground && behave == 2'h0) period = starter ? 50 : (fuel ? 20 : 0);
    if (!mag_ground && starter && behave == 2'h2) period = 100;
  end
  always @(negedge clk) begin
    if (period == 0) begin
      cnt         <= 0;
      speed_pulse <= 1'b0;
    end else begin
      cnt         <= (cnt + 1 >= period) ? 0 : cnt + 1;
      speed_pulse <= (cnt < 2);
    end
  end
endmodule

/* sim/testbench.sv */
// Purpose: Directed test of the start/transfer sequencer
// Assumes: Ten clocks a tick, ten ticks a second
// Notes:   Inputs change just after the falling edge
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TK  = 10;
  localparam int SEC = 10 * TK;
  localparam int ST = 8, MG = 7, FU = 6, TH = 5, CT = 4;
  localparam int RN = 3, PE = 2, SL = 1, SF = 0;
  logic       clk;
  logic       rst;
  logic       sel_auto;
  logic       sel_manual;
  logic       util_low;
  logic       util_high;
  logic       alarm;
  logic       fault_clr;
  logic       exer;
  logic       speed;
  logic [1:0] behave;
  wire  [8:0] outs;
  int         mismatches = 0;
  int         n_compared = 0;
  int         n;
  int         len;

  standby_start_transfer_seq #(
    .TICK_CYCLES(TK), .DROP_PERIOD(60), .RUN_PERIOD(27),
    .STALL_CYCLES(200), .HOLDOFF_S(2)
  ) u_standby_start_transfer_seq (
    .CLK(clk), .RST(rst), .SEL_AUTO(sel_auto), .SEL_MANUAL(sel_manual),
    .EXERCISE_REQ(exer), .UTIL_BELOW_DROP(util_low),
    .UTIL_ABOVE_RETURN(util_high), .SPEED_PULSE(speed),
    .SHUTDOWN_ALARM(alarm), .FAULT_CLEAR(fault_clr),
    .STARTER_ON(outs[ST]), .MAGNETO_GROUND(outs[MG]), .FUEL_ON(outs[FU]),
    .THROTTLE_OPEN(outs[TH]), .CONTACTOR_STANDBY(outs[CT]),
    .ENGINE_RUNNING(outs[RN]), .PROT_ENABLE(outs[PE]),
    .SENSOR_LOSS(outs[SL]), .START_FAILED(outs[SF])
  );
  engine_model u_engine_model (
    .clk(clk), .starter(outs[ST]), .mag_ground(outs[MG]),
    .fuel(outs[FU]), .behave(behave), .speed_pulse(speed)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic got, input logic exp, input string m);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge clk);
  endtask
  // Wait a bounded time for an output to reach a level
  task automatic await(input int i, input logic v, input int lim,
                       input string m);
    int k;
    k = 0;
    while (outs[i] !== v && k < lim) begin
      @(negedge clk);
      k++;
    end
    chk(outs[i], v, m);
  endtask
  // 0 failed, 1 good, 2 between the thresholds
  task automatic util(input int q);
    util_low  = (q == 0);
    util_high = (q == 1);
  endtask
  task automatic clear();
    sel_auto   = 1'b0;
    sel_manual = 1'b0;
    util(1);
    fault_clr  = 1'b1;
    cyc(10);
    fault_clr  = 1'b0;
  endtask
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (50000) @(negedge clk);
    mismatches++;
    $display("BAD t=%0t watchdog", $time);
    conclude();
  end

  initial begin
    rst = 1'b1;
    sel_auto = 1'b0;
    sel_manual = 1'b0;
    alarm = 1'b0;
    fault_clr = 1'b0;
    exer = 1'b0;
    behave = 2'h0;
    util(1);
    cyc(8);
    rst = 1'b0;
    chk(outs[MG], 1'b1, "magneto live");
    chk(outs[ST], 1'b0, "starter on");
    sel_auto = 1'b1;
    util(2);
    cyc(12 * SEC);
    chk(outs[ST], 1'b0, "crank between thresholds");
    util(0);
    cyc(SEC);
    util(2);
    cyc(8 * SEC);
    chk(outs[ST], 1'b0, "crank before delay");
    await(ST, 1'b1, 2 * SEC, "no crank");
    chk(outs[MG], 1'b0, "magneto grounded");
    chk(outs[FU], 1'b0, "fuel with starter");
    await(FU, 1'b1, 20, "no fuel");
    chk(outs[TH], 1'b1, "throttle shut");
    await(ST, 1'b0, 300, "starter past dropout");
    await(RN, 1'b1, 100, "not running");
    cyc(SEC);
    chk(outs[PE], 1'b0, "protections early");
    await(PE, 1'b1, 2 * SEC, "no protections");
    cyc(2 * SEC);
    chk(outs[CT], 1'b0, "early transfer");
    await(CT, 1'b1, SEC, "no transfer");
    util(1);
    cyc(14 * SEC);
    chk(outs[CT], 1'b1, "early retransfer");
    await(CT, 1'b0, 2 * SEC, "no retransfer");
    cyc(10 * SEC);
    util(0);
    cyc(2 * SEC);
    chk(outs[CT], 1'b0, "early standby");
    await(CT, 1'b1, 2 * SEC, "no standby");
    util(1);
    await(CT, 1'b0, 17 * SEC, "no retransfer");
    cyc(58 * SEC);
    chk(outs[RN], 1'b1, "short cool-down");
    await(RN, 1'b0, 3 * SEC, "no stop");
    $display("test auto outage ended");
    util(0);
    await(ST, 1'b1, 12 * SEC, "no crank");
    cyc(20);
    util(1);
    await(RN, 1'b1, 3 * SEC, "crank abandoned");
    cyc(8 * SEC);
    chk(outs[CT], 1'b0, "transfer after return");
    await(RN, 1'b0, 60 * SEC, "no stop");
    $display("test early return ended");
    behave = 2'h1;
    util(0);
    await(ST, 1'b1, 12 * SEC, "no crank");
    cyc(28 * TK);
    chk(outs[SL], 1'b0, "early sensor loss");
    await(SL, 1'b1, SEC, "no sensor loss");
    cyc(2);
    chk(outs[ST], 1'b0, "starter kept");
    fault_clr = 1'b1;
    cyc(6);
    chk(outs[SL], 1'b0, "clear ignored");
    clear();
    chk(outs[SL], 1'b0, "fault kept");
    $display("test sensor loss ended");
    behave = 2'h2;
    sel_auto = 1'b1;
    util(0);
    for (int i = 0; i < 5; i++) begin
      await(ST, 1'b1, 12 * SEC, "no crank cycle");
      n = 0;
      while (outs[ST] === 1'b1 && n < 20 * SEC) begin
        cyc(1);
        n++;
      end
      len = (i < 2) ? 16 * SEC : 7 * SEC;
      chk(n > len - 15 && n < len + 15, 1'b1, "crank length");
      chk(outs[MG], 1'b1, "magneto live at rest");
    end
    await(SF, 1'b1, 8 * SEC, "no failed start");
    clear();
    $display("test crank cycles ended");
    behave = 2'h0;
    sel_auto = 1'b1;
    exer = 1'b1;
    await(RN, 1'b1, 8 * SEC, "no exercise run");
    cyc(6 * SEC);
    chk(outs[CT], 1'b0, "exercise transfer");
    util(0);
    cyc(9 * SEC);
    chk(outs[CT], 1'b0, "early exercise transfer");
    await(CT, 1'b1, 2 * SEC, "no exercise transfer");
    exer = 1'b0;
    clear();
    $display("test exercise ended");
    sel_manual = 1'b1;
    await(RN, 1'b1, 10 * SEC, "no manual run");
    util(0);
    cyc(9 * SEC);
    chk(outs[CT], 1'b0, "early transfer");
    await(CT, 1'b1, 2 * SEC, "no transfer");
    util(1);
    cyc(14 * SEC);
    chk(outs[CT], 1'b1, "early return");
    await(CT, 1'b0, 2 * SEC, "no return");
    chk(outs[RN], 1'b1, "manual run ended");
    util(0);
    await(CT, 1'b1, 11 * SEC, "no transfer");
    util(1);
    alarm = 1'b1;
    cyc(10);
    chk(outs[CT], 1'b0, "contactor kept");
    chk(outs[MG], 1'b1, "engine kept");
    clear();
    alarm = 1'b0;
    behave = 2'h2;
    sel_manual = 1'b1;
    await(ST, 1'b1, 8 * SEC, "no manual crank");
    cyc(SEC);
    sel_manual = 1'b0;
    cyc(6);
    chk(outs[ST], 1'b0, "crank kept");
    $display("test manual ended");
    conclude();
  end
endmodule
